// ### pkg/slc_pkg.sv
package slc_pkg;

  // ----------------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int IDX_W  = 6;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------
  // Register indices, byte address is four times the index
  // ----------------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_TUNE    = 6'h00;
  localparam logic [IDX_W-1:0] IDX_OUTMUX  = 6'h02;
  localparam logic [IDX_W-1:0] IDX_OSC     = 6'h03;
  localparam logic [IDX_W-1:0] IDX_CFG     = 6'h05;
  localparam logic [IDX_W-1:0] IDX_STAT    = 6'h06;
  localparam logic [IDX_W-1:0] IDX_IRQ_ST  = 6'h07;
  localparam logic [IDX_W-1:0] IDX_IRQ_MSK = 6'h08;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam logic [31:0] CFG_RST      = 32'h0040_0005;
  localparam logic [31:0] CFG_WMASK    = 32'h01C4_0000;
  localparam logic [2:0]  STAT_CODE    = 3'h6;
  localparam int          CFG_INTF_BIT = 24;
  localparam int          CFG_LD_LSB   = 22;
  localparam int          CFG_MUX_BIT  = 18;
  localparam int          FRAC_LSB     = 3;
  localparam int          OUTMUX_LSB   = 26;
  localparam int          OSC_LSB      = 26;
  localparam int          AUTO_OFF_BIT = 25;
  localparam int          IRQ_W        = 2;
  localparam int          IRQ_LOCK_ON  = 0;
  localparam int          IRQ_LOCK_OFF = 1;
  localparam logic        POR_RST      = 1'b1;

  typedef enum logic [1:0] {
    SLC_LD_LOW  = 2'h0,
    SLC_LD_DIG  = 2'h1,
    SLC_LD_ANA  = 2'h2,
    SLC_LD_HIGH = 2'h3
  } slc_ld_t;

  // ----------------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------------
  function automatic logic is_mapped(input logic [IDX_W-1:0] idx);
    case (idx)
      IDX_TUNE, IDX_OUTMUX, IDX_OSC, IDX_CFG,
      IDX_STAT, IDX_IRQ_ST, IDX_IRQ_MSK: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : is_mapped

  function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : apply_strb

endpackage : slc_pkg

// ### pkg/slc_reg_if.sv
`timescale 1ns/1ps
interface slc_reg_if;
  logic        wr_req;
  logic        rd_req;
  logic [5:0]  wr_idx;
  logic [5:0]  rd_idx;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic [31:0] rdata;

  modport bus  (output wr_req, rd_req, wr_idx, rd_idx, wdata, wstrb,
                input  rdata);
  modport core (input  wr_req, rd_req, wr_idx, rd_idx, wdata, wstrb,
                output rdata);
endinterface : slc_reg_if

// ### rtl/slc_axil_slave.sv
`timescale 1ns/1ps
module slc_axil_slave (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [7:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [7:0]  s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  slc_reg_if.bus           regs
);

  typedef struct packed {
    logic        aw_got;
    logic        w_got;
    logic [5:0]  widx;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [5:0]  ridx;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        wr_req;
    logic        rd_req;
  } slc_axil_state_t;

  slc_axil_state_t s_reg;
  slc_axil_state_t s_next;

  always_comb begin
    s_next        = s_reg;
    s_next.wr_req = 1'b0;
    s_next.rd_req = 1'b0;
    if (s_axi_awvalid_in && s_reg.awready) begin
      s_next.aw_got = 1'b1;
      s_next.widx   = s_axi_awaddr_in[7:2];
    end
    if (s_axi_wvalid_in && s_reg.wready) begin
      s_next.w_got = 1'b1;
      s_next.wdata = s_axi_wdata_in;
      s_next.wstrb = s_axi_wstrb_in;
    end
    if (s_reg.bvalid && s_axi_bready_in) begin
      s_next.bvalid = 1'b0;
    end
    // Address and data may arrive in either order; act once both are held.
    if (s_next.aw_got && s_next.w_got && !s_next.bvalid) begin
      s_next.wr_req = 1'b1;
      s_next.bvalid = 1'b1;
      s_next.aw_got = 1'b0;
      s_next.w_got  = 1'b0;
      s_next.bresp  = slc_pkg::is_mapped(s_next.widx) ?
                      slc_pkg::RESP_OKAY : slc_pkg::RESP_SLVERR;
    end
    s_next.awready = !s_next.aw_got && !s_next.bvalid;
    s_next.wready  = !s_next.w_got && !s_next.bvalid;
    if (s_axi_arvalid_in && s_reg.arready) begin
      s_next.rd_req  = 1'b1;
      s_next.ridx    = s_axi_araddr_in[7:2];
      s_next.arready = 1'b0;
    end
    if (s_reg.rd_req) begin
      s_next.rvalid = 1'b1;
      s_next.rdata  = regs.rdata;
      s_next.rresp  = slc_pkg::is_mapped(s_reg.ridx) ?
                      slc_pkg::RESP_OKAY : slc_pkg::RESP_SLVERR;
    end
    if (s_reg.rvalid && s_axi_rready_in) begin
      s_next.rvalid  = 1'b0;
      s_next.arready = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_reg         <= '0;
      s_reg.awready <= 1'b1;
      s_reg.wready  <= 1'b1;
      s_reg.arready <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign s_axi_awready_out = s_reg.awready;
  assign s_axi_wready_out  = s_reg.wready;
  assign s_axi_bresp_out   = s_reg.bresp;
  assign s_axi_bvalid_out  = s_reg.bvalid;
  assign s_axi_arready_out = s_reg.arready;
  assign s_axi_rdata_out   = s_reg.rdata;
  assign s_axi_rresp_out   = s_reg.rresp;
  assign s_axi_rvalid_out  = s_reg.rvalid;
  assign regs.wr_req       = s_reg.wr_req;
  assign regs.rd_req       = s_reg.rd_req;
  assign regs.wr_idx       = s_reg.widx;
  assign regs.rd_idx       = s_reg.ridx;
  assign regs.wdata        = s_reg.wdata;
  assign regs.wstrb        = s_reg.wstrb;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking slv_cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  AST_B_HOLD: assert property (
    s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
    else $error("Write response dropped before it was taken.");
  AST_R_LAT: assert property (
    s_axi_arvalid_in && s_axi_arready_out |=> ##1 s_axi_rvalid_out)
    else $error("Read data not returned two cycles after the address.");

endmodule : slc_axil_slave

// ### rtl/slc_top.sv
// What this block does
// - Integer mode when the zero-fraction bit is set and the fraction is zero.
// - Lock pin select: 00 low, 01 digital lock, 10 analog lock, 11 high.
// - Mux MSB with three low select bits picks the muxed output source.
// - Register index 000101 picks config, 000110 picks status; all six index bits are decoded.
// - The status register is read only.
// - Startup flag reads one until first read back, then zero.
// - Status bits 22:20 return the tuning voltage conversion result.
// - Status bits 8:3 report the active oscillator index, 0 to 63.
// - Config register resets to 00400005 hex.
// - With auto selection off, the oscillator index comes from the host.
// - Writing the tuning word last makes the device retune.
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
module slc_top (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [7:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [7:0]  s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  input  wire logic        digital_lock_in,
  input  wire logic        analog_lock_in,
  input  wire logic [2:0]  tuning_voltage_adc_in,
  input  wire logic [5:0]  auto_osc_index_in,
  input  wire logic [15:0] outmux_src_in,
  output logic             lock_detect_out,
  output logic             muxed_output_pin_out,
  output logic             int_mode_out,
  output logic [5:0]       osc_index_out,
  output logic             retune_out,
  output logic             irq_out
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [31:0]                 cfg;
    logic [11:0]                 frac;
    logic [2:0]                  outmux_lo;
    logic [5:0]                  osc_man;
    logic                        auto_off;
    logic                        por;
    logic [2:0]                  adc;
    logic [5:0]                  osc_act;
    logic [slc_pkg::IRQ_W-1:0]   irq_st;
    logic [slc_pkg::IRQ_W-1:0]   irq_msk;
    logic                        dlock_q;
    logic                        int_mode;
    logic                        lock_pin;
    logic                        mux_pin;
    logic                        retune;
    logic                        irq;
  } slc_core_state_t;

  localparam slc_core_state_t CORE_RST = '{
    cfg:     slc_pkg::CFG_RST,
    por:     slc_pkg::POR_RST,
    default: '0
  };

  slc_core_state_t s_reg;
  slc_core_state_t s_next;
  slc_reg_if       regs ();

  slc_axil_slave u_slave (
    .sys_clk_in        (sys_clk_in),
    .rst_n_in          (rst_n_in),
    .s_axi_awaddr_in   (s_axi_awaddr_in),
    .s_axi_awvalid_in  (s_axi_awvalid_in),
    .s_axi_awready_out (s_axi_awready_out),
    .s_axi_wdata_in    (s_axi_wdata_in),
    .s_axi_wstrb_in    (s_axi_wstrb_in),
    .s_axi_wvalid_in   (s_axi_wvalid_in),
    .s_axi_wready_out  (s_axi_wready_out),
    .s_axi_bresp_out   (s_axi_bresp_out),
    .s_axi_bvalid_out  (s_axi_bvalid_out),
    .s_axi_bready_in   (s_axi_bready_in),
    .s_axi_araddr_in   (s_axi_araddr_in),
    .s_axi_arvalid_in  (s_axi_arvalid_in),
    .s_axi_arready_out (s_axi_arready_out),
    .s_axi_rdata_out   (s_axi_rdata_out),
    .s_axi_rresp_out   (s_axi_rresp_out),
    .s_axi_rvalid_out  (s_axi_rvalid_out),
    .s_axi_rready_in   (s_axi_rready_in),
    .regs              (regs)
  );

  // ----------------------------------------------------------------------
  // Register views
  // ----------------------------------------------------------------------
  logic [31:0] tune_w;
  logic [31:0] outmux_w;
  logic [31:0] osc_w;
  logic [31:0] stat_w;
  logic [31:0] irq_st_w;
  logic [31:0] irq_msk_w;
  logic [3:0]  mux_sel;
  logic        stat_rd;
  logic        irq_rd;

  assign tune_w    = {17'h0, s_reg.frac, 3'h0};
  assign outmux_w  = {3'h0, s_reg.outmux_lo, 26'h0};
  assign osc_w     = {s_reg.osc_man, s_reg.auto_off, 25'h0};
  assign stat_w    = {8'h0, s_reg.por, s_reg.adc, 11'h0,
                      s_reg.osc_act, slc_pkg::STAT_CODE};
  assign irq_st_w  = {30'h0, s_reg.irq_st};
  assign irq_msk_w = {30'h0, s_reg.irq_msk};
  assign mux_sel   = {s_reg.cfg[slc_pkg::CFG_MUX_BIT], s_reg.outmux_lo};
  assign stat_rd   = regs.rd_req && (regs.rd_idx == slc_pkg::IDX_STAT);
  assign irq_rd    = regs.rd_req && (regs.rd_idx == slc_pkg::IDX_IRQ_ST);

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  // The word is sampled by the slave in the same cycle as the read strobe,
  // so read-to-clear effects below land after the old value is captured.
  always_comb begin
    case (regs.rd_idx)
      slc_pkg::IDX_TUNE:    regs.rdata = tune_w;
      slc_pkg::IDX_OUTMUX:  regs.rdata = outmux_w;
      slc_pkg::IDX_OSC:     regs.rdata = osc_w;
      slc_pkg::IDX_CFG:     regs.rdata = s_reg.cfg;
      slc_pkg::IDX_STAT:    regs.rdata = stat_w;
      slc_pkg::IDX_IRQ_ST:  regs.rdata = irq_st_w;
      slc_pkg::IDX_IRQ_MSK: regs.rdata = irq_msk_w;
      default:              regs.rdata = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic [31:0]               w;
    logic [slc_pkg::IRQ_W-1:0] ev;
    w      = 32'h0000_0000;
    ev     = '0;
    s_next = s_reg;
    s_next.retune = 1'b0;
    if (regs.wr_req) begin
      case (regs.wr_idx)
        slc_pkg::IDX_TUNE: begin
          w = slc_pkg::apply_strb(tune_w, regs.wdata, regs.wstrb);
          s_next.frac   = w[slc_pkg::FRAC_LSB +: 12];
          s_next.retune = 1'b1;
        end
        slc_pkg::IDX_OUTMUX: begin
          w = slc_pkg::apply_strb(outmux_w, regs.wdata, regs.wstrb);
          s_next.outmux_lo = w[slc_pkg::OUTMUX_LSB +: 3];
        end
        slc_pkg::IDX_OSC: begin
          w = slc_pkg::apply_strb(osc_w, regs.wdata, regs.wstrb);
          s_next.osc_man  = w[slc_pkg::OSC_LSB +: 6];
          s_next.auto_off = w[slc_pkg::AUTO_OFF_BIT];
        end
        slc_pkg::IDX_CFG: begin
          // Reserved bits and the code field are held at fixed values.
          w = slc_pkg::apply_strb(s_reg.cfg, regs.wdata, regs.wstrb);
          s_next.cfg = (w & slc_pkg::CFG_WMASK) |
                       (slc_pkg::CFG_RST & ~slc_pkg::CFG_WMASK);
        end
        slc_pkg::IDX_IRQ_MSK: begin
          s_next.irq_msk = regs.wdata[slc_pkg::IRQ_W-1:0];
        end
        default: begin
          // Status and event registers ignore writes.
          s_next.cfg = s_reg.cfg;
        end
      endcase
    end
    if (stat_rd) begin
      s_next.por = 1'b0;
    end
    s_next.adc = tuning_voltage_adc_in;
    // A manual index only takes effect on the retune strobe, so the host
    // may stage it before the tuning word without disturbing the loop.
    if (!s_reg.auto_off) begin
      s_next.osc_act = auto_osc_index_in;
    end else if (s_reg.retune) begin
      s_next.osc_act = s_reg.osc_man;
    end
    s_next.int_mode = s_reg.cfg[slc_pkg::CFG_INTF_BIT] &&
                      (s_reg.frac == 12'h000);
    case (slc_pkg::slc_ld_t'(s_reg.cfg[slc_pkg::CFG_LD_LSB +: 2]))
      slc_pkg::SLC_LD_LOW:  s_next.lock_pin = 1'b0;
      slc_pkg::SLC_LD_DIG:  s_next.lock_pin = digital_lock_in;
      slc_pkg::SLC_LD_ANA:  s_next.lock_pin = analog_lock_in;
      slc_pkg::SLC_LD_HIGH: s_next.lock_pin = 1'b1;
      default:              s_next.lock_pin = 1'b0;
    endcase
    s_next.mux_pin = outmux_src_in[mux_sel];
    s_next.dlock_q = digital_lock_in;
    ev[slc_pkg::IRQ_LOCK_ON]  = digital_lock_in && !s_reg.dlock_q;
    ev[slc_pkg::IRQ_LOCK_OFF] = !digital_lock_in && s_reg.dlock_q;
    // A new event in the clearing cycle survives the read.
    s_next.irq_st = (s_reg.irq_st & ~{slc_pkg::IRQ_W{irq_rd}}) | ev;
    s_next.irq    = |(s_next.irq_st & s_next.irq_msk);
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_reg <= CORE_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign lock_detect_out      = s_reg.lock_pin;
  assign muxed_output_pin_out = s_reg.mux_pin;
  assign int_mode_out         = s_reg.int_mode;
  assign osc_index_out        = s_reg.osc_act;
  assign retune_out           = s_reg.retune;
  assign irq_out              = s_reg.irq;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking core_cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  logic first_q;
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  AST_INT_MODE: assert property (
    int_mode_out == $past(s_reg.cfg[slc_pkg::CFG_INTF_BIT] &&
                          s_reg.frac == 12'h000) || first_q)
    else $error("Integer mode does not follow flag and fraction.");
  AST_LOCK_DIG: assert property (
    s_reg.cfg[23:22] == 2'h1 |=> lock_detect_out == $past(digital_lock_in))
    else $error("Lock pin does not follow digital lock.");
  AST_LOCK_HIGH: assert property (
    s_reg.cfg[23:22] == 2'h3 |=> lock_detect_out)
    else $error("Lock pin not high when forced high.");
  AST_MUX_PIN: assert property (
    ##1 muxed_output_pin_out == $past(outmux_src_in[mux_sel]))
    else $error("Muxed pin does not follow the selected source.");
  AST_CFG_RESET: assert property (
    first_q |-> s_reg.cfg == 32'h0040_0005)
    else $error("Config register not at its reset value.");
  AST_CFG_CODE: assert property (
    s_reg.cfg[2:0] == 3'h5 && stat_w[2:0] == 3'h6)
    else $error("Register code field corrupted.");
  AST_STAT_RO: assert property (
    regs.wr_req && regs.wr_idx == slc_pkg::IDX_STAT && !regs.rd_req
    |=> $stable(s_reg.por))
    else $error("Write to status changed the startup flag.");
  AST_POR_CLR: assert property (
    stat_rd |=> !s_reg.por ##1 !s_reg.por)
    else $error("Startup flag not cleared by read back.");
  AST_OSC_MAN: assert property (
    retune_out && s_reg.auto_off |=> osc_index_out == $past(s_reg.osc_man))
    else $error("Manual oscillator index not applied on retune.");
  AST_RETUNE: assert property (
    regs.wr_req && regs.wr_idx == slc_pkg::IDX_TUNE |=> retune_out ##1
    !retune_out || $past(regs.wr_req))
    else $error("Tuning write did not pulse the retune strobe.");
  AST_IRQ: assert property (
    ##1 irq_out == |(s_reg.irq_st & s_reg.irq_msk))
    else $error("Interrupt output disagrees with status and mask.");

  COV_CFG_WR: cover property (
    regs.wr_req && regs.wr_idx == slc_pkg::IDX_CFG);
  COV_STAT_RD: cover property (stat_rd && s_reg.por);
  COV_MANUAL: cover property (retune_out && s_reg.auto_off);
  COV_IRQ: cover property ($rose(irq_out));

endmodule : slc_top

// ### verif/slc_pll_model.sv
`timescale 1ns/1ps
// -----------------------------------------------------------------------
// Loop model: lock drops on each retune and returns after a settling time
// -----------------------------------------------------------------------
module slc_pll_model #(
  parameter int LOCK_CYC = 4
) (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic retune_in,
  output logic      lock_out
);
  int cnt;

  // Lock is not instant, so a host that polls too early sees it low.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt      <= 0;
      lock_out <= 1'b0;
    end else if (retune_in) begin
      cnt      <= 0;
      lock_out <= 1'b0;
    end else if (cnt < LOCK_CYC) begin
      cnt <= cnt + 1;
    end else begin
      lock_out <= 1'b1;
    end
  end
endmodule : slc_pll_model

// ### verif/tb.sv
`timescale 1ns/1ps
module tb;
  logic        clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic        arvalid = 0, rready = 0, alock = 0;
  logic        awready, wready, bvalid, arready, rvalid, dlock;
  logic        ld, mo, im, rt, irq;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rd_d, s = 32'h0000_3d06;
  logic [3:0]  wstrb = 4'hf;
  logic [2:0]  adc = 0;
  logic [5:0]  aidx = 0, oidx;
  logic [15:0] src = 0;
  logic [1:0]  bresp, rresp, resp;
  int          fails = 0, compares = 0, nrt = 0;
  int          wt;
  logic [5:0]  exp_q[$], tab[$];

  always #4 clk = ~clk;

  slc_top uut (.sys_clk_in(clk), .rst_n_in(rst_n),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .digital_lock_in(dlock),
    .analog_lock_in(alock), .tuning_voltage_adc_in(adc),
    .auto_osc_index_in(aidx), .outmux_src_in(src),
    .lock_detect_out(ld), .muxed_output_pin_out(mo), .int_mode_out(im),
    .osc_index_out(oidx), .retune_out(rt), .irq_out(irq));

  slc_pll_model pll (.clk_in(clk), .rst_n_in(rst_n), .retune_in(rt),
    .lock_out(dlock));

  always @(posedge clk) if (rt === 1'b1) nrt++;

  task automatic end_of_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid === 1'b1) break;
    end
    bready <= 0;
    resp = bresp;
    if (n == 40) begin fails++; end_of_test(); end
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge clk);
    araddr <= a; arvalid <= 1; rready <= 1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid === 1'b1) break;
    end
    rready <= 0;
    rd_d = rdata;
    resp = rresp;
    if (n == 40) begin fails++; end_of_test(); end
  endtask : rd

  function automatic logic [31:0] lf(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lf

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1;
    s = lf(lf(s));
    adc <= s[2:0]; aidx <= s[8:3]; alock <= s[9]; src <= s[31:16];
    rd(8'h14); chk(rd_d, 32'h0040_0005);
    for (int i = 0; i < 2; i++) begin
      rd(8'h18); chk(rd_d, {8'h0, ~i[0], adc, 11'h0, aidx, 3'h6});
    end
    wr(8'h20, 32'h0000_0001); repeat (2) @(posedge clk); chk(irq, 1);
    rd(8'h1C); chk(rd_d, 32'h0000_0001); chk(irq, 0);
    $display("test status and interrupt done");
    wr(8'h18, 32'hFFFF_FFFF); chk(resp, 0);
    rd(8'h18); chk(rd_d, {9'h0, adc, 11'h0, aidx, 3'h6});
    wr(8'h3C, 32'h0000_0000); chk(resp, 2);
    rd(8'h3C); chk(resp, 2); chk(rd_d, 0);
    wr(8'h14, 32'h01C4_0005); rd(8'h14); chk(rd_d, 32'h01C4_0005);
    $display("test write protection done");
    for (int i = 0; i < 4; i++) begin
      wr(8'h14, {8'h0, i[1:0], 19'h0, 3'h5}); repeat (3) @(posedge clk);
      chk(ld, i == 0 ? 0 : i == 1 ? dlock : i == 2 ? alock : 1);
    end
    wr(8'h08, 32'h1400_0000); wr(8'h14, 32'h0004_0005);
    repeat (3) @(posedge clk); chk(mo, src[13]);
    for (int i = 0; i < 4; i++) begin
      wr(8'h14, {7'h0, i[1], 21'h0, 3'h5}); wr(8'h00, {28'h0, i[0], 3'h0});
      repeat (3) @(posedge clk); chk(im, i == 2);
    end
    $display("test pin functions done");
    wr(8'h14, 32'h0040_0005);
    for (int k = 0; k < 2; k++) begin
      s = lf(s); aidx <= s[8:3]; exp_q.push_back(s[8:3]);
      // The old lock level lingers for two edges after the tuning write.
      wr(8'h00, {28'h0, k[0], 3'h0}); repeat (3) @(posedge clk);
      for (wt = 0; wt < 40 && ld !== 1'b1; wt++) @(posedge clk);
      if (wt == 40) begin fails++; end_of_test(); end
      rd(8'h18); tab.push_back(rd_d[8:3]);
      chk(rd_d[8:3], exp_q[k]);
    end
    $display("test lookup table done");
    wr(8'h0C, {6'd42, 1'b1, 25'h0}); repeat (2) @(posedge clk);
    chk(oidx, aidx);
    wr(8'h00, 32'h0000_0000); repeat (4) @(posedge clk);
    chk(oidx, 42);
    rd(8'h18); chk(rd_d[8:3], 42);
    for (int j = 1; j >= 0; j--) begin
      wr(8'h0C, {tab[j], 1'b1, 25'h0});
      wr(8'h00, {28'h0, j[0], 3'h0}); repeat (2) @(posedge clk);
      chk(oidx, exp_q[j]);
    end
    chk(nrt, 9);
    $display("test manual oscillator done");
    end_of_test();
  end
endmodule : tb
